// ==== shared/sdw_pkg.sv ====
/*
 * Constants, field layouts and types for the slow clock dual watchdog.
 * Assumes a byte-wide register view placed on a 32-bit AXI4-Lite bus.
 */
package sdw_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [15:0] CFG2_IDX = 16'ha0d8;
    localparam logic [15:0] LIM2L_IDX = 16'ha0d9;
    localparam logic [15:0] LIM2H_IDX = 16'ha0da;
    localparam logic [15:0] CFG3_IDX = 16'ha0db;
    localparam logic [15:0] LIM3L_IDX = 16'ha0dc;
    localparam logic [15:0] LIM3H_IDX = 16'ha0dd;
    localparam logic [15:0] STS_IDX = 16'ha0de;
    localparam logic [15:0] MASK_IDX = 16'ha0df;
    localparam logic [15:0] UNLOCK_IDX = 16'ha0e0;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CFG2_RST = 8'h00;
    localparam logic [7:0] LIM2L_RST = 8'hff;
    localparam logic [7:0] LIM2H_RST = 8'h0f;
    localparam logic [7:0] CFG3_RST = 8'hd1;
    localparam logic [7:0] LIM3L_RST = 8'h3f;
    localparam logic [7:0] LIM3H_RST = 8'h00;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CLR_BIT = 7;
    localparam int REN_BIT = 6;
    localparam int RF2_BIT = 5;
    localparam int IEN_BIT = 4;
    localparam int CODE_LSB = 1;
    localparam int IF_BIT = 0;
    localparam int HALT_LSB = 4;
    localparam int RF3_BIT = 0;
    localparam int EV_HIT2 = 0;
    localparam int EV_RST2 = 1;
    localparam int EV_RST3 = 2;
    // ------------------------------------------------------------
    // Codes and dividers
    // ------------------------------------------------------------
    localparam logic [2:0] HALT_KEY = 3'b101;
    localparam logic [4:0] PRE2_BASE = 5'h08;
    localparam logic [4:0] PRE3_BASE = 5'h0a;
    localparam logic [7:0] KEY1 = 8'haa;
    localparam logic [7:0] KEY2 = 8'h55;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic ren;
        logic rf;
        logic ien;
        logic [2:0] code;
        logic iflag;
    } sdw_cfg2_t;
    typedef struct packed {
        logic [2:0] halt;
        logic rf;
    } sdw_cfg3_t;
    typedef enum logic [1:0] {LK_IDLE, LK_KEY1, LK_OPEN} sdw_lock_t;
endpackage

// ==== rtl/sdw_top.sv ====
/*
 * Slow clock dual watchdog: two watchdog counters, AXI4-Lite registers.
 * Assumes the slow oscillator arrives as a level on sosc_i, much slower
 * than mclk_i, and that wdt_reset_o feeds the system reset logic.
 */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module sdw_top
    import sdw_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic sosc_i,
    input wire logic low_power_i,
    input wire logic s_awvalid_i,
    input wire logic [31:0] s_awaddr_i,
    input wire logic s_wvalid_i,
    input wire logic [31:0] s_wdata_i,
    input wire logic [3:0] s_wstrb_i,
    input wire logic s_bready_i,
    input wire logic s_arvalid_i,
    input wire logic [31:0] s_araddr_i,
    input wire logic s_rready_i,
    output logic s_awready_o,
    output logic s_wready_o,
    output logic s_bvalid_o,
    output logic [1:0] s_bresp_o,
    output logic s_arready_o,
    output logic s_rvalid_o,
    output logic [31:0] s_rdata_o,
    output logic [1:0] s_rresp_o,
    output logic irq_o,
    output logic wdt_reset_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // ------------------------------------------------------------
    // Slow oscillator synchroniser and prescaler
    // ------------------------------------------------------------
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic [17:0] pre_reg;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= sosc_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end
    wire sosc_rise = sync2_reg & ~sync3_reg;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pre_reg <= '0;
        end else if (sosc_rise) begin
            pre_reg <= pre_reg + 18'h00001;
        end
    end

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    sdw_cfg2_t cfg2_reg;
    sdw_cfg2_t cfg2_next;
    sdw_cfg3_t cfg3_reg;
    sdw_cfg3_t cfg3_next;
    sdw_lock_t lk_reg;
    sdw_lock_t lk_next;
    logic [15:0] lim2_reg;
    logic [15:0] lim3_reg;
    logic [15:0] cnt2_reg;
    logic [15:0] cnt2_next;
    logic [15:0] cnt3_reg;
    logic [15:0] cnt3_next;
    logic [2:0] sts_reg;
    logic [2:0] sts_next;
    logic [2:0] mask_reg;

    // ------------------------------------------------------------
    // Tick generation
    // ------------------------------------------------------------
    wire [4:0] sh2 = PRE2_BASE + {2'b00, cfg2_reg.code};
    wire [4:0] sh3 = PRE3_BASE + {2'b00, cfg2_reg.code};
    wire [17:0] m2 = ~(18'h3ffff << sh2);
    wire [17:0] m3 = ~(18'h3ffff << sh3);
    wire tick2 = sosc_rise & ((pre_reg & m2) == m2);
    wire tick3 = sosc_rise & ((pre_reg & m3) == m3);
    wire halt3 = low_power_i & (cfg3_reg.halt == HALT_KEY);
    wire run3 = tick3 & ~halt3;
    wire hit2 = tick2 & (cnt2_reg == lim2_reg);
    wire hit3 = run3 & (cnt3_reg == lim3_reg);
    wire rst2 = hit2 & cfg2_reg.ren;

    // ------------------------------------------------------------
    // AXI4-Lite handshake
    // ------------------------------------------------------------
    logic awready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    wire aw_go = s_awvalid_i & s_wvalid_i & ~awready_reg & ~bvalid_reg;
    wire wr_take = awready_reg;
    wire ar_go = s_arvalid_i & ~arready_reg & ~rvalid_reg;
    wire rd_take = arready_reg;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire wa_cfg2 = s_awaddr_i == {14'h0000, CFG2_IDX, 2'b00};
    wire wa_lim2l = s_awaddr_i == {14'h0000, LIM2L_IDX, 2'b00};
    wire wa_lim2h = s_awaddr_i == {14'h0000, LIM2H_IDX, 2'b00};
    wire wa_cfg3 = s_awaddr_i == {14'h0000, CFG3_IDX, 2'b00};
    wire wa_lim3l = s_awaddr_i == {14'h0000, LIM3L_IDX, 2'b00};
    wire wa_lim3h = s_awaddr_i == {14'h0000, LIM3H_IDX, 2'b00};
    wire wa_sts = s_awaddr_i == {14'h0000, STS_IDX, 2'b00};
    wire wa_mask = s_awaddr_i == {14'h0000, MASK_IDX, 2'b00};
    wire wa_unl = s_awaddr_i == {14'h0000, UNLOCK_IDX, 2'b00};
    wire wa_wd = wa_cfg2 | wa_lim2l | wa_lim2h | wa_cfg3 | wa_lim3l | wa_lim3h;
    wire wa_ok = wa_wd | wa_sts | wa_mask | wa_unl;
    wire wr_en = wr_take & s_wstrb_i[0];
    wire [7:0] wd = s_wdata_i[7:0];
    wire wd_open = wr_en & wa_wd & (lk_reg == LK_OPEN);
    wire w_cfg2 = wd_open & wa_cfg2;
    wire w_cfg3 = wd_open & wa_cfg3;
    wire clr2 = w_cfg2 & wd[CLR_BIT];
    wire clr3 = w_cfg3 & wd[CLR_BIT];

    wire ra_cfg2 = s_araddr_i == {14'h0000, CFG2_IDX, 2'b00};
    wire ra_lim2l = s_araddr_i == {14'h0000, LIM2L_IDX, 2'b00};
    wire ra_lim2h = s_araddr_i == {14'h0000, LIM2H_IDX, 2'b00};
    wire ra_cfg3 = s_araddr_i == {14'h0000, CFG3_IDX, 2'b00};
    wire ra_lim3l = s_araddr_i == {14'h0000, LIM3L_IDX, 2'b00};
    wire ra_lim3h = s_araddr_i == {14'h0000, LIM3H_IDX, 2'b00};
    wire ra_sts = s_araddr_i == {14'h0000, STS_IDX, 2'b00};
    wire ra_mask = s_araddr_i == {14'h0000, MASK_IDX, 2'b00};
    wire ra_unl = s_araddr_i == {14'h0000, UNLOCK_IDX, 2'b00};
    wire ra_ok = ra_cfg2 | ra_lim2l | ra_lim2h | ra_cfg3 | ra_lim3l | ra_lim3h
        | ra_sts | ra_mask | ra_unl;
    wire [7:0] cfg2_rd = {1'b0, cfg2_reg.ren, cfg2_reg.rf, cfg2_reg.ien,
        cfg2_reg.code, cfg2_reg.iflag};
    wire [7:0] cfg3_rd = {1'b0, cfg3_reg.halt, 3'b000, cfg3_reg.rf};
    // Limit addresses read back the live count
    wire [7:0] rd_byte = ra_cfg2 ? cfg2_rd :
        ra_lim2l ? cnt2_reg[7:0] :
        ra_lim2h ? cnt2_reg[15:8] :
        ra_cfg3 ? cfg3_rd :
        ra_lim3l ? cnt3_reg[7:0] :
        ra_lim3h ? cnt3_reg[15:8] :
        ra_sts ? {5'h00, sts_reg} :
        ra_mask ? {5'h00, mask_reg} :
        ra_unl ? {6'h00, lk_reg} :
        8'h00;
    wire rd_sts = rd_take & ra_sts;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            awready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            awready_reg <= aw_go;
            if (wr_take) begin
                bvalid_reg <= 1'b1;
                bresp_reg <= wa_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_bready_i) begin
                bvalid_reg <= 1'b0;
            end
        end
    end
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else begin
            arready_reg <= ar_go;
            if (rd_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= {24'h000000, rd_byte};
                rresp_reg <= ra_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_rready_i) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------
    wire w_unl = wr_en & wa_unl;
    always_comb begin
        lk_next = lk_reg;
        case (lk_reg)
            LK_IDLE: begin
                if (w_unl && wd == KEY1) begin
                    lk_next = LK_KEY1;
                end
            end
            LK_KEY1: begin
                if (w_unl && wd == KEY2) begin
                    lk_next = LK_OPEN;
                end else if (wr_en) begin
                    lk_next = LK_IDLE;
                end
            end
            default: begin
                if (w_unl && wd == KEY1) begin
                    lk_next = LK_KEY1;
                end else if (wr_en && (wa_wd || w_unl)) begin
                    lk_next = LK_IDLE;
                end
            end
        endcase
    end

    // ------------------------------------------------------------
    // Configuration and flags
    // ------------------------------------------------------------
    always_comb begin
        cfg2_next = cfg2_reg;
        cfg3_next = cfg3_reg;
        if (w_cfg2) begin
            cfg2_next.ren = wd[REN_BIT];
            cfg2_next.ien = wd[IEN_BIT];
            cfg2_next.code = wd[CODE_LSB +: 3];
            if (!wd[RF2_BIT]) begin
                cfg2_next.rf = 1'b0;
            end
            if (!wd[IF_BIT]) begin
                cfg2_next.iflag = 1'b0;
            end
        end
        if (w_cfg3) begin
            cfg3_next.halt = wd[HALT_LSB +: 3];
            if (!wd[RF3_BIT]) begin
                cfg3_next.rf = 1'b0;
            end
        end
        // Hardware set wins over a same-cycle clear
        if (rst2) begin
            cfg2_next.rf = 1'b1;
        end
        if (hit2) begin
            cfg2_next.iflag = 1'b1;
        end
        if (hit3) begin
            cfg3_next.rf = 1'b1;
        end
    end
    assign sts_next = (rd_sts ? 3'b000 : sts_reg) | {hit3, rst2, hit2};

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    always_comb begin
        cnt2_next = cnt2_reg;
        if (clr2 || hit2) begin
            cnt2_next = '0;
        end else if (tick2) begin
            cnt2_next = cnt2_reg + 16'h0001;
        end
        cnt3_next = cnt3_reg;
        if (clr3 || hit3) begin
            cnt3_next = '0;
        end else if (run3) begin
            cnt3_next = cnt3_reg + 16'h0001;
        end
    end

    logic irq_reg;
    logic rsto_reg;
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cfg2_reg <= CFG2_RST[6:0];
            cfg3_reg <= {CFG3_RST[HALT_LSB +: 3], CFG3_RST[RF3_BIT]};
            lim2_reg <= {LIM2H_RST, LIM2L_RST};
            lim3_reg <= {LIM3H_RST, LIM3L_RST};
            cnt2_reg <= '0;
            cnt3_reg <= '0;
            sts_reg <= '0;
            mask_reg <= '0;
            lk_reg <= LK_IDLE;
            irq_reg <= 1'b0;
            rsto_reg <= 1'b0;
        end else begin
            cfg2_reg <= cfg2_next;
            cfg3_reg <= cfg3_next;
            cnt2_reg <= cnt2_next;
            cnt3_reg <= cnt3_next;
            sts_reg <= sts_next;
            lk_reg <= lk_next;
            if (wd_open && wa_lim2l) begin
                lim2_reg[7:0] <= wd;
            end
            if (wd_open && wa_lim2h) begin
                lim2_reg[15:8] <= wd;
            end
            if (wd_open && wa_lim3l) begin
                lim3_reg[7:0] <= wd;
            end
            if (wd_open && wa_lim3h) begin
                lim3_reg[15:8] <= wd;
            end
            if (wr_en && wa_mask) begin
                mask_reg <= wd[2:0];
            end
            irq_reg <= (cfg2_reg.iflag & cfg2_reg.ien) | (|(sts_reg & mask_reg));
            rsto_reg <= rst2 | hit3;
        end
    end

    assign s_awready_o = awready_reg;
    assign s_wready_o = awready_reg;
    assign s_bvalid_o = bvalid_reg;
    assign s_bresp_o = bresp_reg;
    assign s_arready_o = arready_reg;
    assign s_rvalid_o = rvalid_reg;
    assign s_rdata_o = rdata_reg;
    assign s_rresp_o = rresp_reg;
    assign irq_o = irq_reg;
    assign wdt_reset_o = rsto_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_hit3;
        hit3;
    endsequence
    sequence s_reset_out;
        ##1 wdt_reset_o && cfg3_reg.rf;
    endsequence

    a_clr2_zero: assert property (clr2 |=> cnt2_reg == 16'h0000)
        else $error("second counter not cleared");
    a_rst2_out: assert property (hit2 && cfg2_reg.ren |=> wdt_reset_o && cfg2_reg.rf)
        else $error("second timeout reset missing");
    a_rf2_hold: assert property (cfg2_reg.rf && !w_cfg2 |=> cfg2_reg.rf)
        else $error("second reset flag dropped");
    a_irq_gate: assert property (cfg2_reg.iflag && !cfg2_reg.ien && mask_reg == 3'b000
        |=> !irq_o)
        else $error("interrupt passed while disabled");
    a_hit2_irq: assert property (hit2 && cfg2_reg.ien |=> cfg2_reg.iflag ##1 irq_o)
        else $error("second match interrupt missing");
    a_tick_ratio: assert property (tick3 |-> tick2)
        else $error("third tick without second tick");
    a_halt3_hold: assert property (halt3 && !clr3 |=> cnt3_reg == $past(cnt3_reg))
        else $error("third counter moved while halted");
    a_run3_count: assert property (run3 && !clr3 && !hit3 && !low_power_i
        |=> cnt3_reg == $past(cnt3_reg) + 16'h0001)
        else $error("third counter failed to count");
    a_hit3_reset: assert property (s_hit3 |-> s_reset_out)
        else $error("third timeout reset missing");
    a_lock_guard: assert property (wr_en && wa_cfg2 && lk_reg != LK_OPEN
        |=> cfg2_reg.code == $past(cfg2_reg.code))
        else $error("locked write took effect");
    a_lim_read: assert property (rd_take && ra_lim2l && !tick2 && !clr2
        |=> s_rdata_o[7:0] == cnt2_reg[7:0])
        else $error("limit read not live count");

endmodule

`default_nettype wire

// ==== verif/tb_sdw_top.sv ====
/*
 * Self-checking testbench for the slow clock dual watchdog top.
 * Assumes sdw_pkg is compiled first; the bench drives every port itself.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_sdw_top;
    import sdw_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic sosc_i = 1'b0;
    logic low_power_i = 1'b0;
    logic s_awvalid_i = 1'b0, s_wvalid_i = 1'b0, s_bready_i = 1'b0;
    logic s_arvalid_i = 1'b0, s_rready_i = 1'b0;
    logic [31:0] s_awaddr_i = 32'h0, s_wdata_i = 32'h0, s_araddr_i = 32'h0;
    logic [3:0] s_wstrb_i = 4'h0;
    logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, irq_o, wdt_reset_o;
    logic [1:0] s_bresp_o, s_rresp_o;
    logic [31:0] s_rdata_o;
    logic [31:0] rdw;
    logic [1:0] resp;
    logic [2:0] code;
    logic [7:0] lim;
    int error_cnt = 0, check_count = 0, cyc = 0, rst_n = 0, prev_t = 0, last_t = 0;
    int sdiv = 0, n0, t0, hi;

    sdw_top sdw_top_inst (.mclk_i(mclk_i), .rst_i(rst_i), .sosc_i(sosc_i),
        .low_power_i(low_power_i), .s_awvalid_i(s_awvalid_i), .s_awaddr_i(s_awaddr_i),
        .s_wvalid_i(s_wvalid_i), .s_wdata_i(s_wdata_i), .s_wstrb_i(s_wstrb_i),
        .s_bready_i(s_bready_i), .s_arvalid_i(s_arvalid_i), .s_araddr_i(s_araddr_i),
        .s_rready_i(s_rready_i), .s_awready_o(s_awready_o), .s_wready_o(s_wready_o),
        .s_bvalid_o(s_bvalid_o), .s_bresp_o(s_bresp_o), .s_arready_o(s_arready_o),
        .s_rvalid_o(s_rvalid_o), .s_rdata_o(s_rdata_o), .s_rresp_o(s_rresp_o),
        .irq_o(irq_o), .wdt_reset_o(wdt_reset_o));

    // ------------------------------------------------------------
    // Clocks and monitors
    // ------------------------------------------------------------
    always #25 mclk_i = ~mclk_i;

    // Free-running slow oscillator, 8 system cycles a period
    always @(posedge mclk_i) begin
        if (sdiv == 3) begin
            sdiv <= 0;
            sosc_i <= ~sosc_i;
        end else begin
            sdiv <= sdiv + 1;
        end
    end

    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (wdt_reset_o === 1'b1) begin
            rst_n <= rst_n + 1;
            prev_t <= last_t;
            last_t <= cyc;
        end
    end

    // ------------------------------------------------------------
    // Expectations and helpers
    // ------------------------------------------------------------
    function automatic int tick2(input logic [2:0] c);
        return 8 << (8 + int'(c));
    endfunction

    function automatic int tick3(input logic [2:0] c);
        return 8 << (10 + int'(c));
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            error_cnt++;
        end
    endtask

    task automatic tmo(input string nm);
        $display("mismatch %s expected handshake seen timeout", nm);
        error_cnt++;
        finish_test();
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        int n;
        s_awvalid_i <= 1'b1;
        s_wvalid_i <= 1'b1;
        s_bready_i <= 1'b1;
        s_awaddr_i <= {14'h0, idx, 2'b00};
        s_wdata_i <= {24'h0, d};
        s_wstrb_i <= 4'hf;
        for (n = 0; n < 64; n++) begin
            @(posedge mclk_i);
            if (s_awready_o === 1'b1 && s_wready_o === 1'b1) break;
        end
        if (n == 64) tmo("write_addr");
        s_awvalid_i <= 1'b0;
        s_wvalid_i <= 1'b0;
        for (n = 0; n < 64; n++) begin
            @(posedge mclk_i);
            if (s_bvalid_o === 1'b1) break;
        end
        if (n == 64) tmo("write_resp");
        resp = s_bresp_o;
        s_bready_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    task automatic rd(input logic [15:0] idx);
        int n;
        s_arvalid_i <= 1'b1;
        s_rready_i <= 1'b1;
        s_araddr_i <= {14'h0, idx, 2'b00};
        for (n = 0; n < 64; n++) begin
            @(posedge mclk_i);
            if (s_arready_o === 1'b1) break;
        end
        if (n == 64) tmo("read_addr");
        s_arvalid_i <= 1'b0;
        for (n = 0; n < 64; n++) begin
            @(posedge mclk_i);
            if (s_rvalid_o === 1'b1) break;
        end
        if (n == 64) tmo("read_data");
        rdw = s_rdata_o;
        resp = s_rresp_o;
        s_rready_i <= 1'b0;
        @(posedge mclk_i);
    endtask

    // Unlock, then one protected write
    task automatic pwr(input logic [15:0] idx, input logic [7:0] d);
        wr(UNLOCK_IDX, KEY1);
        wr(UNLOCK_IDX, KEY2);
        wr(idx, d);
    endtask

    task automatic wait_irq(input int bound, input string nm);
        int n;
        for (n = 0; n < bound; n++) begin
            @(posedge mclk_i);
            if (irq_o === 1'b1) break;
        end
        if (n == bound) tmo(nm);
    endtask

    task automatic wait_pulse(input int bound, input string nm);
        int n;
        int base;
        base = rst_n;
        for (n = 0; n < bound; n++) begin
            @(posedge mclk_i);
            if (rst_n != base) break;
        end
        if (n == bound) tmo(nm);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hb32b));
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        rd(CFG2_IDX);
        chk("cfg2_reset", 32'h0, rdw);
        rd(CFG3_IDX);
        chk("cfg3_reset", 32'h51, rdw);
        rd(LIM2L_IDX);
        chk("count2_reset", 32'h0, rdw);
        rd(16'h0040);
        chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        chk("unmapped_data", 32'h0, rdw);
        wr(CFG2_IDX, 8'h10);
        chk("locked_bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
        rd(CFG2_IDX);
        chk("locked_write", 32'h0, rdw);
        pwr(CFG2_IDX, 8'h10);
        rd(CFG2_IDX);
        chk("unlocked_write", 32'h10, rdw);
        $display("test reset_and_lock done");

        pwr(LIM2H_IDX, 8'hff);
        pwr(LIM2L_IDX, 8'hff);
        repeat (3 * tick2(3'd0) + 64) @(posedge mclk_i);
        rd(LIM2L_IDX);
        chk("count2_runs", 32'h1, {31'h0, rdw >= 32'd2});
        pwr(CFG2_IDX, 8'h80);
        repeat (8) @(posedge mclk_i);
        rd(LIM2L_IDX);
        chk("count2_clear", 32'h0, rdw);
        rd(CFG2_IDX);
        chk("clear2_self", 32'h0, rdw);
        $display("test clear2 done");

        code = 3'($urandom_range(1, 0));
        lim = 8'($urandom_range(2, 1));
        pwr(LIM2H_IDX, 8'h00);
        pwr(LIM2L_IDX, lim);
        pwr(CFG2_IDX, 8'h90 | {4'h0, code, 1'b0});
        t0 = cyc;
        wait_irq((int'(lim) + 1) * tick2(code) + 64, "irq2");
        chk("irq_time", 32'h1, {31'h0, cyc - t0 >= int'(lim) * tick2(code) - 64});
        rd(CFG2_IDX);
        chk("irq_flag_set", 32'h11 | (32'(code) << 1), rdw);
        pwr(CFG2_IDX, {4'h0, code, 1'b0});
        rd(CFG2_IDX);
        chk("irq_flag_clear", 32'(code) << 1, rdw);
        repeat (4) @(posedge mclk_i);
        chk("irq_off", 32'h0, {31'h0, irq_o});
        hi = 0;
        repeat ((int'(lim) + 2) * tick2(code)) begin
            @(posedge mclk_i);
            if (irq_o !== 1'b0) hi++;
        end
        chk("irq_gated", 32'h0, 32'(hi));
        rd(CFG2_IDX);
        chk("flag_sticky", 32'h1 | (32'(code) << 1), rdw);
        $display("test irq2 done");

        pwr(LIM2L_IDX, 8'h02);
        pwr(CFG2_IDX, 8'hc0);
        wait_pulse(3 * tick2(3'd0) + 64, "reset2");
        rd(CFG2_IDX);
        chk("rflag2_set", 32'h61, rdw);
        pwr(CFG2_IDX, 8'h20);
        rd(CFG2_IDX);
        chk("rflag2_hold", 32'h20, rdw);
        pwr(CFG2_IDX, 8'h00);
        n0 = rst_n;
        repeat (3 * tick2(3'd0) + 64) @(posedge mclk_i);
        chk("no_reset2", 32'(n0), 32'(rst_n));
        rd(CFG2_IDX);
        chk("rflag2_clear", 32'h0, rdw & 32'h20);
        $display("test reset2 done");

        rd(STS_IDX);
        wr(MASK_IDX, 8'h01);
        wait_irq(3 * tick2(3'd0) + 64, "status_irq");
        rd(STS_IDX);
        chk("status_hit2", 32'h1, rdw & 32'h1);
        repeat (4) @(posedge mclk_i);
        chk("status_cleared", 32'h0, {31'h0, irq_o});
        wr(MASK_IDX, 8'h00);
        $display("test status_mask done");

        pwr(LIM3L_IDX, 8'h00);
        pwr(CFG3_IDX, 8'hd0);
        rd(CFG3_IDX);
        chk("cfg3_clear", 32'h50, rdw);
        wait_pulse(tick3(3'd0) + 64, "reset3a");
        wait_pulse(tick3(3'd0) + 64, "reset3b");
        repeat (2) @(posedge mclk_i);
        chk("period3", 32'(tick3(3'd0)), 32'(last_t - prev_t));
        rd(CFG3_IDX);
        chk("rflag3_set", 32'h51, rdw);
        $display("test third done");

        low_power_i <= 1'b1;
        pwr(CFG3_IDX, 8'hd0);
        n0 = rst_n;
        repeat (2 * tick3(3'd0) + 64) @(posedge mclk_i);
        chk("halt3", 32'(n0), 32'(rst_n));
        rd(LIM3L_IDX);
        chk("halt3_count", 32'h0, rdw);
        pwr(CFG3_IDX, 8'h80);
        wait_pulse(tick3(3'd0) + 64, "nohalt3");
        low_power_i <= 1'b0;
        $display("test low_power done");
        finish_test();
    end
endmodule
`default_nettype wire
